// *** src/rtc_pkg.sv ***
// Constants shared by the RTC oscillator control and the timer/alarm logic.
// Assumes a 50 MHz core clock; the oscillator arrives as a sampled level.
package rtc_pkg;
  localparam int unsigned CORE_PERIOD_NS = 20;
  localparam int unsigned TIMER_W = 32;
  localparam int unsigned LOAD_CAP_SELECT_W = 4;
  localparam int unsigned CNT_W = 20;
  typedef logic [CNT_W-1:0] cnt_t;
  typedef logic [LOAD_CAP_SELECT_W-1:0] load_cap_select_t;
  typedef logic [TIMER_W-1:0] timer_t;

  // Missing-clock limit: a longest time, rounded down
  localparam int unsigned MISSING_TIME_US = 100;
  localparam int unsigned MISSING_CYCLES = (MISSING_TIME_US * 1000) / CORE_PERIOD_NS;
  // Clock-valid blanking: a least time, rounded up
  localparam int unsigned BLANK_TIME_MS = 2;
  localparam int unsigned BLANK_CYCLES = (BLANK_TIME_MS * 1000000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // Dwell per load capacitance step during automatic stepping
  localparam int unsigned LOAD_CAP_SELECT_STEP_US = 500;
  localparam int unsigned LOAD_CAP_SELECT_STEP_CYCLES = (LOAD_CAP_SELECT_STEP_US * 1000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  localparam timer_t TIMER_RST = 32'h0000_0000;
  localparam load_cap_select_t LOAD_CAP_SELECT_RST = 4'h0;
  localparam cnt_t CNT_RST = 20'h0_0000;
endpackage : rtc_pkg

// *** src/osc_mon_if.sv ***
// Signals between the timer top and the oscillator monitor.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface osc_mon_if;
  logic osc_change;
  logic power_en;
  logic crystal_mode;
  logic amplitude_ok;
  logic mcd_en;
  logic fail_clear;
  logic step_en;
  rtc_pkg::load_cap_select_t load_cap_select;
  logic fail;
  logic clk_valid;
  logic load_ready;
  rtc_pkg::load_cap_select_t load_cap_applied;

  modport ctrl (
    output osc_change, power_en, crystal_mode, amplitude_ok, mcd_en, fail_clear, step_en, load_cap_select,
    input fail, clk_valid, load_ready, load_cap_applied
  );
  modport mon (
    input osc_change, power_en, crystal_mode, amplitude_ok, mcd_en, fail_clear, step_en, load_cap_select,
    output fail, clk_valid, load_ready, load_cap_applied
  );
endinterface : osc_mon_if

// *** src/osc_monitor.sv ***
// Missing-clock detector, clock-valid blanking and load capacitance stepping.
// Assumes osc_change is a one-cycle pulse per oscillator level change.
`timescale 1ns/10ps
module osc_monitor #(
  parameter int unsigned MISSING_CYCLES = rtc_pkg::MISSING_CYCLES,
  parameter int unsigned BLANK_CYCLES = rtc_pkg::BLANK_CYCLES,
  parameter int unsigned STEP_CYCLES = rtc_pkg::LOAD_CAP_SELECT_STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  osc_mon_if.mon m
);
  localparam rtc_pkg::cnt_t MISS_LIM = rtc_pkg::cnt_t'(MISSING_CYCLES);
  localparam rtc_pkg::cnt_t BLANK_LIM = rtc_pkg::cnt_t'(BLANK_CYCLES);
  localparam rtc_pkg::cnt_t STEP_LIM = rtc_pkg::cnt_t'(STEP_CYCLES);

  rtc_pkg::cnt_t miss_cnt_q;
  rtc_pkg::cnt_t blank_cnt_q;
  rtc_pkg::cnt_t step_cnt_q;
  logic fail_q;
  logic valid_q;
  logic ready_q;
  rtc_pkg::load_cap_select_t applied_q;
  logic fail_set;

  assign fail_set = m.mcd_en && !m.osc_change && (miss_cnt_q == MISS_LIM);
  assign m.fail = fail_q;
  assign m.clk_valid = valid_q;
  assign m.load_ready = ready_q;
  assign m.load_cap_applied = applied_q;

  // Time since the last level change; saturates at the limit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      miss_cnt_q <= rtc_pkg::CNT_RST;
    end else if (!m.mcd_en || m.osc_change) begin
      miss_cnt_q <= rtc_pkg::CNT_RST;
    end else if (miss_cnt_q != MISS_LIM) begin
      miss_cnt_q <= miss_cnt_q + rtc_pkg::cnt_t'(1);
    end
  end

  // Sticky; a new failure outranks a clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fail_q <= 1'b0;
    end else begin
      fail_q <= fail_set || (fail_q && !m.fail_clear);
    end
  end

  // Amplitude detector output is ignored until the blanking time has run
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      blank_cnt_q <= rtc_pkg::CNT_RST;
    end else if (!(m.power_en && m.crystal_mode)) begin
      blank_cnt_q <= rtc_pkg::CNT_RST;
    end else if (blank_cnt_q != BLANK_LIM) begin
      blank_cnt_q <= blank_cnt_q + rtc_pkg::cnt_t'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= m.power_en && m.crystal_mode && m.amplitude_ok && (blank_cnt_q == BLANK_LIM);
    end
  end

  // Stepping starts from the smallest setting at power-up; lowering jumps at once
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      applied_q <= rtc_pkg::LOAD_CAP_SELECT_RST;
      step_cnt_q <= rtc_pkg::CNT_RST;
    end else if (!m.power_en) begin
      applied_q <= m.step_en ? rtc_pkg::LOAD_CAP_SELECT_RST : m.load_cap_select;
      step_cnt_q <= rtc_pkg::CNT_RST;
    end else if (!m.step_en || applied_q >= m.load_cap_select) begin
      applied_q <= m.load_cap_select;
      step_cnt_q <= rtc_pkg::CNT_RST;
    end else if (step_cnt_q == STEP_LIM) begin
      applied_q <= applied_q + rtc_pkg::load_cap_select_t'(1);
      step_cnt_q <= rtc_pkg::CNT_RST;
    end else begin
      step_cnt_q <= step_cnt_q + rtc_pkg::cnt_t'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= m.power_en && (applied_q == m.load_cap_select);
    end
  end

  AST_FAIL_AFTER_TIMEOUT: assert property (@(posedge core_clk) disable iff (reset)
    (m.mcd_en && !m.osc_change) [*2] ##0 (miss_cnt_q == MISS_LIM) |=> fail_q)
    else $error("missing clock not flagged after timeout");
  AST_FAIL_STICKY: assert property (@(posedge core_clk) disable iff (reset)
    fail_q && !m.fail_clear |=> fail_q)
    else $error("failure flag dropped without a clear");
  AST_VALID_BLANKED: assert property (@(posedge core_clk) disable iff (reset)
    valid_q |-> $past(blank_cnt_q) == BLANK_LIM && $past(m.power_en))
    else $error("clock valid shown inside the blanking time");
  AST_STEP_BY_ONE: assert property (@(posedge core_clk) disable iff (reset)
    m.power_en && m.step_en && $stable(m.load_cap_select) && applied_q < m.load_cap_select
      |=> applied_q == $past(applied_q) || applied_q == $past(applied_q) + rtc_pkg::load_cap_select_t'(1))
    else $error("load capacitance stepped by more than one");
  AST_READY_AT_FINAL: assert property (@(posedge core_clk) disable iff (reset)
    m.power_en && $stable(m.load_cap_select) && applied_q == m.load_cap_select |=> ready_q)
    else $error("load ready not set at final value");
endmodule : osc_monitor

// *** src/rtc_osc_timer_alarm.sv ***
// RTC unit: 32-bit timer with alarm and auto reset, oscillator control outputs.
// Assumes control bits are plain ports held by the host-side register logic;
// osc_in_pin is the oscillator output level, synchronous to core_clk.
`timescale 1ns/10ps
module rtc_osc_timer_alarm #(
  parameter int unsigned MISSING_CYCLES = rtc_pkg::MISSING_CYCLES,
  parameter int unsigned BLANK_CYCLES = rtc_pkg::BLANK_CYCLES,
  parameter int unsigned STEP_CYCLES = rtc_pkg::LOAD_CAP_SELECT_STEP_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Oscillator pin side
  input wire logic osc_in_pin,
  input wire logic osc_amplitude_ok,
  // Oscillator control
  input wire logic osc_power_en,
  input wire logic crystal_mode_select,
  input wire logic gain_control_en,
  input wire logic bias_double_en,
  input wire logic load_cap_auto_step_en,
  input wire logic [3:0] load_cap_select,
  input wire logic missing_clock_detect_en,
  input wire logic osc_fail_clear,
  // Timer control
  input wire logic timer_run,
  input wire logic alarm_flag_wr,
  input wire logic alarm_flag_wdata,
  input wire logic timer_set_wr,
  input wire logic [31:0] capture_value,
  input wire logic [31:0] alarm_compare,
  // Event routing
  input wire logic alarm_irq_en,
  input wire logic alarm_wake_en,
  input wire logic alarm_reset_en,
  input wire logic mclk_irq_en,
  input wire logic mclk_wake_en,
  input wire logic mclk_reset_en,
  // Analog controls
  output logic osc_power_out,
  output logic crystal_mode_out,
  output logic gain_control_out,
  output logic bias_double_out,
  output logic [3:0] load_cap_applied,
  // Status
  output logic [31:0] timer_value,
  output logic timer_set_request,
  output logic alarm_flag_autoreset,
  output logic alarm_event,
  output logic oscillator_fail_flag,
  output logic clock_valid_flag,
  output logic load_cap_ready,
  // Routed events
  output logic alarm_irq,
  output logic alarm_wake,
  output logic alarm_reset,
  output logic mclk_irq,
  output logic mclk_wake,
  output logic mclk_reset
);
  osc_mon_if mon_bus ();

  // Oscillator sampling
  logic osc_q;
  logic osc_prev_q;
  logic osc_tick;
  // Timer and auto reset
  rtc_pkg::timer_t timer_q;
  rtc_pkg::timer_t timer_d;
  logic timer_upd;
  logic set_req_q;
  logic autoreset_q;
  // Alarm and missing clock events
  logic alarm_event_q;
  logic alarm_hit;
  logic alarm_irq_q;
  logic alarm_wake_q;
  logic alarm_reset_q;
  logic mclk_irq_q;
  logic mclk_wake_q;
  logic mclk_reset_q;
  // Analog control mirrors
  logic power_q;
  logic crystal_q;
  logic gain_q;
  logic bias_q;

  // Oscillator level history; one tick per rising edge
  // Both flops reset to the idle pin level, so no false tick follows reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      osc_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_q <= osc_in_pin;
      osc_prev_q <= osc_q;
    end
  end

  assign osc_tick = osc_q && !osc_prev_q;

  assign mon_bus.osc_change = osc_q ^ osc_prev_q;
  assign mon_bus.power_en = osc_power_en;
  assign mon_bus.crystal_mode = crystal_mode_select;
  assign mon_bus.amplitude_ok = osc_amplitude_ok;
  assign mon_bus.mcd_en = missing_clock_detect_en;
  assign mon_bus.fail_clear = osc_fail_clear;
  assign mon_bus.step_en = load_cap_auto_step_en;
  assign mon_bus.load_cap_select = load_cap_select;

  osc_monitor #(
    .MISSING_CYCLES(MISSING_CYCLES),
    .BLANK_CYCLES(BLANK_CYCLES),
    .STEP_CYCLES(STEP_CYCLES)
  ) u_osc_monitor (
    .core_clk(core_clk),
    .reset(reset),
    .m(mon_bus.mon)
  );

  // Analog control mirrors
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      power_q <= 1'b0;
      crystal_q <= 1'b0;
      gain_q <= 1'b0;
      bias_q <= 1'b0;
    end else begin
      power_q <= osc_power_en;
      crystal_q <= crystal_mode_select;
      gain_q <= gain_control_en;
      bias_q <= bias_double_en;
    end
  end

  // Next timer value; a pending set outranks counting on the same tick
  always_comb begin
    timer_d = timer_q;
    timer_upd = 1'b0;
    if (osc_tick) begin
      if (set_req_q) begin
        timer_d = capture_value;
        timer_upd = 1'b1;
      end else if (timer_run) begin
        timer_upd = 1'b1;
        // Old value still at compare: the match shows for one full tick
        if (autoreset_q && (timer_q == alarm_compare)) begin
          timer_d = rtc_pkg::TIMER_RST;
        end else begin
          timer_d = timer_q + rtc_pkg::timer_t'(1);
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_q <= rtc_pkg::TIMER_RST;
    end else begin
      timer_q <= timer_d;
    end
  end

  // Request stays up until the next oscillator tick takes it; a new write wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      set_req_q <= 1'b0;
    end else begin
      set_req_q <= timer_set_wr || (set_req_q && !osc_tick);
    end
  end

  // Alarm flag position written as 1 arms auto reset, 0 disarms it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      autoreset_q <= 1'b0;
    end else if (alarm_flag_wr) begin
      autoreset_q <= alarm_flag_wdata;
    end
  end

  // Event marks the arrival of the timer at the compare value
  assign alarm_hit = timer_upd && (timer_d == alarm_compare);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      alarm_event_q <= 1'b0;
      alarm_irq_q <= 1'b0;
      alarm_wake_q <= 1'b0;
      alarm_reset_q <= 1'b0;
    end else begin
      alarm_event_q <= alarm_hit;
      alarm_irq_q <= alarm_hit && alarm_irq_en;
      alarm_wake_q <= alarm_hit && alarm_wake_en;
      alarm_reset_q <= alarm_hit && alarm_reset_en;
    end
  end

  // Missing clock routes follow the sticky flag as levels
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mclk_irq_q <= 1'b0;
      mclk_wake_q <= 1'b0;
      mclk_reset_q <= 1'b0;
    end else begin
      mclk_irq_q <= mon_bus.fail && mclk_irq_en;
      mclk_wake_q <= mon_bus.fail && mclk_wake_en;
      mclk_reset_q <= mon_bus.fail && mclk_reset_en;
    end
  end

  assign osc_power_out = power_q;
  assign crystal_mode_out = crystal_q;
  assign gain_control_out = gain_q;
  assign bias_double_out = bias_q;
  assign load_cap_applied = mon_bus.load_cap_applied;
  assign timer_value = timer_q;
  assign timer_set_request = set_req_q;
  assign alarm_flag_autoreset = autoreset_q;
  assign alarm_event = alarm_event_q;
  assign oscillator_fail_flag = mon_bus.fail;
  assign clock_valid_flag = mon_bus.clk_valid;
  assign load_cap_ready = mon_bus.load_ready;
  assign alarm_irq = alarm_irq_q;
  assign alarm_wake = alarm_wake_q;
  assign alarm_reset = alarm_reset_q;
  assign mclk_irq = mclk_irq_q;
  assign mclk_wake = mclk_wake_q;
  assign mclk_reset = mclk_reset_q;

  AST_TIMER_ONLY_ON_TICK: assert property (@(posedge core_clk) disable iff (reset)
    !(osc_q && !osc_prev_q) |=> $stable(timer_value))
    else $error("timer moved without an oscillator edge");
  AST_TIMER_INCREMENT: assert property (@(posedge core_clk) disable iff (reset)
    osc_tick && timer_run && !set_req_q && !(autoreset_q && timer_value == alarm_compare)
      |=> timer_value == $past(timer_value) + 32'h0000_0001)
    else $error("running timer did not advance by one");
  AST_TIMER_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !timer_run && !set_req_q && !timer_set_wr |=> $stable(timer_value))
    else $error("stopped timer changed");
  AST_AUTORESET_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    osc_tick && timer_run && !set_req_q && alarm_flag_autoreset && timer_value == alarm_compare
      |=> timer_value == 32'h0000_0000)
    else $error("auto reset did not clear the timer");
  AST_AUTORESET_ARM: assert property (@(posedge core_clk) disable iff (reset)
    alarm_flag_wr && alarm_flag_wdata |=> alarm_flag_autoreset ##1 (alarm_flag_autoreset || $past(alarm_flag_wr)))
    else $error("auto reset not armed by write of one");
  AST_ALARM_ON_MATCH: assert property (@(posedge core_clk) disable iff (reset)
    $changed(timer_value) && $stable(alarm_compare) && timer_value == alarm_compare |-> alarm_event)
    else $error("timer reached compare without alarm");
  AST_ALARM_ONLY_ON_MATCH: assert property (@(posedge core_clk) disable iff (reset)
    alarm_event && $stable(alarm_compare) |-> timer_value == alarm_compare && $changed(timer_value) ##1 !alarm_event)
    else $error("alarm without a match or held too long");
  AST_ALARM_ROUTE: assert property (@(posedge core_clk) disable iff (reset)
    (alarm_irq || alarm_wake || alarm_reset) |-> alarm_event && (alarm_reset == $past(alarm_reset_en)))
    else $error("alarm route without alarm event");
  AST_SET_LOAD: assert property (@(posedge core_clk) disable iff (reset)
    osc_tick && timer_set_request && !timer_set_wr |=> timer_value == $past(capture_value) && !timer_set_request)
    else $error("set request did not load capture and clear");
  AST_MCLK_ROUTE: assert property (@(posedge core_clk) disable iff (reset)
    mclk_irq == ($past(oscillator_fail_flag) && $past(mclk_irq_en))
      && mclk_wake == ($past(oscillator_fail_flag) && $past(mclk_wake_en))
      && mclk_reset == ($past(oscillator_fail_flag) && $past(mclk_reset_en)))
    else $error("missing clock route does not follow the flag");
  AST_BIAS_DOUBLE: assert property (@(posedge core_clk) disable iff (reset)
    bias_double_en [*2] |-> bias_double_out)
    else $error("bias doubling not applied");
  AST_BIAS_FOLLOW: assert property (@(posedge core_clk) disable iff (reset)
    !bias_double_en [*2] |-> !bias_double_out)
    else $error("bias doubling applied while not requested");
  AST_SET_REQUEST_RISE: assert property (@(posedge core_clk) disable iff (reset)
    timer_set_wr |=> timer_set_request)
    else $error("set request not raised by a write");
  AST_AUTORESET_DISARM: assert property (@(posedge core_clk) disable iff (reset)
    alarm_flag_wr && !alarm_flag_wdata |=> !alarm_flag_autoreset)
    else $error("auto reset not disarmed by write of zero");
  AST_ALARM_ROUTE_LEVELS: assert property (@(posedge core_clk) disable iff (reset)
    alarm_event |-> alarm_irq == $past(alarm_irq_en) && alarm_wake == $past(alarm_wake_en)
      && alarm_reset == $past(alarm_reset_en))
    else $error("alarm route does not follow its enable");
  AST_ALARM_PULSE_ONE: assert property (@(posedge core_clk) disable iff (reset)
    alarm_event |=> !alarm_event)
    else $error("alarm event longer than one cycle");
  AST_RUN_STOP_TICK: assert property (@(posedge core_clk) disable iff (reset)
    osc_tick && !timer_run && !set_req_q |=> $stable(timer_value))
    else $error("stopped timer moved on an oscillator edge");
endmodule : rtc_osc_timer_alarm

// *** tb/rtc_osc_timer_alarm_tb.sv ***
// Self-checking bench for the RTC timer, alarm and oscillator monitor.
// Assumes short monitor counts; the oscillator is a level driven on falling edges.
`timescale 1ns/10ps
module rtc_osc_timer_alarm_tb;
  localparam int MC = 20;
  localparam int BC = 30;
  localparam int SC = 4;
  logic core_clk = 1'b0, reset = 1'b1, osc_in_pin = 1'b0, osc_amplitude_ok = 1'b1;
  logic osc_power_en = 1'b0, crystal_mode_select = 1'b0, gain_control_en = 1'b0, bias_double_en = 1'b0;
  logic load_cap_auto_step_en = 1'b0, missing_clock_detect_en = 1'b0, osc_fail_clear = 1'b0;
  logic timer_run = 1'b0, alarm_flag_wr = 1'b0, alarm_flag_wdata = 1'b0, timer_set_wr = 1'b0;
  logic alarm_irq_en = 1'b0, alarm_wake_en = 1'b0, alarm_reset_en = 1'b0;
  logic mclk_irq_en = 1'b0, mclk_wake_en = 1'b0, mclk_reset_en = 1'b0;
  logic [3:0] load_cap_select = 4'h0;
  logic [31:0] capture_value = 32'h0000_0000, alarm_compare = 32'h8000_0000;
  logic osc_power_out, crystal_mode_out, gain_control_out, bias_double_out;
  logic [3:0] load_cap_applied;
  logic [31:0] timer_value;
  logic timer_set_request, alarm_flag_autoreset, alarm_event, oscillator_fail_flag, clock_valid_flag;
  logic load_cap_ready, alarm_irq, alarm_wake, alarm_reset, mclk_irq, mclk_wake, mclk_reset;
  int fails = 0, compares = 0;
  int n_alarm = 0, n_irq = 0, n_wake = 0, n_rst = 0, n;
  // Row: power, crystal, gain, bias | expected mirrors | expected clock valid
  // Self-oscillate rows keep gain off, bias picks the rate
  logic [8:0] rows [5] = '{9'b0001_0001_0, 9'b0110_0110_0, 9'b1001_1001_0, 9'b0100_0100_0, 9'b0000_0000_0};
  logic [3:0] prev_cap;

  rtc_osc_timer_alarm #(.MISSING_CYCLES(MC), .BLANK_CYCLES(BC), .STEP_CYCLES(SC)) u_dut (
    .core_clk(core_clk), .reset(reset), .osc_in_pin(osc_in_pin), .osc_amplitude_ok(osc_amplitude_ok),
    .osc_power_en(osc_power_en), .crystal_mode_select(crystal_mode_select),
    .gain_control_en(gain_control_en), .bias_double_en(bias_double_en),
    .load_cap_auto_step_en(load_cap_auto_step_en), .load_cap_select(load_cap_select),
    .missing_clock_detect_en(missing_clock_detect_en), .osc_fail_clear(osc_fail_clear),
    .timer_run(timer_run), .alarm_flag_wr(alarm_flag_wr), .alarm_flag_wdata(alarm_flag_wdata),
    .timer_set_wr(timer_set_wr), .capture_value(capture_value), .alarm_compare(alarm_compare),
    .alarm_irq_en(alarm_irq_en), .alarm_wake_en(alarm_wake_en), .alarm_reset_en(alarm_reset_en),
    .mclk_irq_en(mclk_irq_en), .mclk_wake_en(mclk_wake_en), .mclk_reset_en(mclk_reset_en),
    .osc_power_out(osc_power_out), .crystal_mode_out(crystal_mode_out),
    .gain_control_out(gain_control_out), .bias_double_out(bias_double_out),
    .load_cap_applied(load_cap_applied), .timer_value(timer_value), .timer_set_request(timer_set_request),
    .alarm_flag_autoreset(alarm_flag_autoreset), .alarm_event(alarm_event),
    .oscillator_fail_flag(oscillator_fail_flag), .clock_valid_flag(clock_valid_flag),
    .load_cap_ready(load_cap_ready), .alarm_irq(alarm_irq), .alarm_wake(alarm_wake),
    .alarm_reset(alarm_reset), .mclk_irq(mclk_irq), .mclk_wake(mclk_wake), .mclk_reset(mclk_reset)
  );

  always #10 core_clk = ~core_clk;

  // One-cycle pulses last a whole cycle, so the falling edge always sees them
  always @(negedge core_clk) begin
    if (alarm_event === 1'b1) n_alarm++;
    if (alarm_irq === 1'b1) n_irq++;
    if (alarm_wake === 1'b1) n_wake++;
    if (alarm_reset === 1'b1) n_rst++;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Bounded wait on a status flag; running out ends the run
  task automatic wait_flag(input int sel, input int limit, output int cnt);
    logic f;
    for (cnt = 0; cnt < limit; cnt++) begin
      f = (sel == 0) ? clock_valid_flag : (sel == 1) ? load_cap_ready : oscillator_fail_flag;
      if (f === 1'b1) break;
      @(negedge core_clk);
    end
    if (cnt >= limit) begin
      fails++;
      $display("ERROR at %0t: flag %0d never rose", $time, sel);
      end_of_test();
    end
  endtask : wait_flag

  // Oscillator cycle long enough for the level sampler to see both halves
  task automatic ticks(input int k);
    repeat (k) begin
      osc_in_pin = 1'b1;
      @(negedge core_clk);
      osc_in_pin = 1'b0;
      repeat (3) @(negedge core_clk);
    end
  endtask : ticks

  task automatic pulse_set(input logic [31:0] v);
    capture_value = v;
    timer_set_wr = 1'b1;
    @(negedge core_clk);
    timer_set_wr = 1'b0;
    check(timer_set_request, 1, "set request");
  endtask : pulse_set

  task automatic write_autoreset(input logic v);
    alarm_flag_wdata = v;
    alarm_flag_wr = 1'b1;
    @(negedge core_clk);
    alarm_flag_wr = 1'b0;
    @(negedge core_clk);
    check(alarm_flag_autoreset, v, "auto reset");
  endtask : write_autoreset

  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    check({timer_value, oscillator_fail_flag}, 0, "reset state");
    foreach (rows[i]) begin
      {osc_power_en, crystal_mode_select, gain_control_en, bias_double_en} = rows[i][8:5];
      repeat (2) @(negedge core_clk);
      check({osc_power_out, crystal_mode_out, gain_control_out, bias_double_out}, rows[i][4:1], "mirrors");
      check(clock_valid_flag, rows[i][0], "valid in row");
    end
    timer_run = 1'b1;
    ticks(5);
    check(timer_value, 5, "counting");
    repeat (40) @(negedge core_clk);
    check(timer_value, 5, "no osc edges");
    timer_run = 1'b0;
    ticks(3);
    check(timer_value, 5, "stopped");
    pulse_set(32'hffff_fffd);
    ticks(1);
    check({timer_value, timer_set_request}, {32'hffff_fffd, 1'b0}, "set load");
    timer_run = 1'b1;
    ticks(3);
    check(timer_value, 0, "wrap");
    // Auto reset: compare one below the wanted period of four
    alarm_compare = 32'h0000_0003;
    {alarm_irq_en, alarm_wake_en, alarm_reset_en} = 3'b111;
    write_autoreset(1'b1);
    ticks(3);
    check(timer_value, 3, "at match");
    check({n_alarm, n_irq, n_wake, n_rst}, {32'd1, 32'd1, 32'd1, 32'd1}, "alarm routes");
    ticks(1);
    check(timer_value, 0, "auto cleared");
    alarm_irq_en = 1'b0;
    ticks(4);
    check({n_alarm, n_irq, n_wake, n_rst}, {32'd2, 32'd1, 32'd2, 32'd2}, "masked route");
    write_autoreset(1'b0);
    ticks(4);
    check(timer_value, 4, "no auto reset");
    // Crystal start-up in the documented order
    crystal_mode_select = 1'b1;
    gain_control_en = 1'b0;
    bias_double_en = 1'b1;
    load_cap_select = 4'h5;
    load_cap_auto_step_en = 1'b1;
    @(negedge core_clk);
    check(load_cap_applied, 0, "cap off");
    osc_power_en = 1'b1;
    repeat (2) @(negedge core_clk);
    check({load_cap_applied, clock_valid_flag}, 0, "start smallest");
    prev_cap = 4'h0;
    for (n = 0; n < 200 && load_cap_ready !== 1'b1; n++) begin
      @(negedge core_clk);
      if (load_cap_applied !== prev_cap) check(load_cap_applied, prev_cap + 4'h1, "step");
      prev_cap = load_cap_applied;
    end
    check({load_cap_applied, load_cap_ready}, {4'h5, 1'b1}, "cap ready");
    wait_flag(0, BC + 10, n);
    check(clock_valid_flag, 1, "valid after blank");
    gain_control_en = 1'b1;
    bias_double_en = 1'b0;
    load_cap_auto_step_en = 1'b0;
    load_cap_select = 4'hf;
    repeat (2) @(negedge core_clk);
    check({load_cap_applied, load_cap_ready}, {4'hf, 1'b1}, "top setting");
    // Detector on while the oscillator runs: no false failure
    missing_clock_detect_en = 1'b1;
    ticks(8);
    check(oscillator_fail_flag, 0, "fail while running");
    {mclk_irq_en, mclk_wake_en, mclk_reset_en} = 3'b110;
    missing_clock_detect_en = 1'b1;
    repeat (MC - 4) @(negedge core_clk);
    check(oscillator_fail_flag, 0, "fail early");
    wait_flag(2, 12, n);
    repeat (2) @(negedge core_clk);
    check({mclk_irq, mclk_wake, mclk_reset}, 3'b110, "mclk routes");
    // Detector off: the failure flag holds through oscillator ticks until a clear
    missing_clock_detect_en = 1'b0;
    ticks(2);
    check(oscillator_fail_flag, 1, "sticky fail");
    osc_fail_clear = 1'b1;
    @(negedge core_clk);
    osc_fail_clear = 1'b0;
    repeat (2) @(negedge core_clk);
    check({oscillator_fail_flag, mclk_irq}, 0, "fail cleared");
    // Mid-run reset: timer cleared, blanking restarts, mirrors follow at once
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    check({timer_value, clock_valid_flag, osc_power_out}, {32'h0000_0000, 1'b0, 1'b1}, "mid-run reset");
    end_of_test();
  end
endmodule : rtc_osc_timer_alarm_tb
